// ===== core/sac_serial_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

module sac_serial_ctrl #(
    parameter int RESULT_W   = sac_pkg::RESULT_W,
    parameter int XFER_BITS  = sac_pkg::XFER_BITS,
    parameter int FIFO_DEPTH = sac_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rst_n,
    // Serial pins
    input  wire logic                            sel_n,
    input  wire logic                            shift_clk,
    input  wire logic                            sdi,
    output logic                                 sdo,
    output logic                                 sdo_oe,
    output logic                                 conv_done,
    // Format
    input  wire logic                            lsb_first,
    // Converter core side
    output logic [sac_pkg::ADDR_BITS-1:0]        chan_sel,
    output logic                                 chan_valid,
    output logic [sac_pkg::CMD_BITS-1:0]         cmd_word,
    output logic                                 sampling,
    output logic                                 conv_start,
    input  wire logic [RESULT_W-1:0]             conv_result
);

    if (RESULT_W != XFER_BITS || XFER_BITS < sac_pkg::CMD_BITS || XFER_BITS > 15) begin : g_bad
        $error("sac_serial_ctrl: transfer length must equal result width, 8 to 15 bits");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic sel_m, sel_s, sel_d;
    logic clk_m, clk_s, clk_d;
    logic sdi_m, sdi_s;
    logic sel_fall, sel_rise, sclk_rise, sclk_fall;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sel_m <= 1'b1;
            sel_s <= 1'b1;
            sel_d <= 1'b1;
            clk_m <= 1'b0;
            clk_s <= 1'b0;
            clk_d <= 1'b0;
            sdi_m <= 1'b0;
            sdi_s <= 1'b0;
        end else begin
            sel_m <= sel_n;
            sel_s <= sel_m;
            sel_d <= sel_s;
            clk_m <= shift_clk;
            clk_s <= clk_m;
            clk_d <= clk_s;
            sdi_m <= sdi;
            sdi_s <= sdi_m;
        end
    end

    // Data and clock share the same synchroniser depth, so rises sample aligned data
    assign sel_fall  = sel_d && !sel_s;
    assign sel_rise  = !sel_d && sel_s;
    assign sclk_rise = clk_s && !clk_d;
    assign sclk_fall = !clk_s && clk_d;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequencing

    sac_pkg::sac_state_t             state;
    logic [sac_pkg::TIMER_W-1:0]     setup_cnt;
    logic [sac_pkg::CNT_W-1:0]       rise_cnt;
    logic [sac_pkg::CNT_W-1:0]       fall_cnt;
    logic                            xfer_rise;
    logic                            xfer_fall;
    logic                            last_fall;

    assign xfer_rise = (state == sac_pkg::SAC_XFER) && sclk_rise;
    assign xfer_fall = (state == sac_pkg::SAC_XFER) && sclk_fall;
    assign last_fall = xfer_fall && (fall_cnt == sac_pkg::CNT_W'(XFER_BITS - 1));

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= sac_pkg::SAC_IDLE;
        end else if (sel_rise) begin
            state <= sac_pkg::SAC_IDLE;
        end else if (sel_fall) begin
            state <= sac_pkg::SAC_SETUP;
        end else begin
            unique case (state)
                sac_pkg::SAC_IDLE: begin
                    state <= sac_pkg::SAC_IDLE;
                end
                sac_pkg::SAC_SETUP: begin
                    if (setup_cnt == sac_pkg::TIMER_W'(sac_pkg::SETUP_CYC - 1)) begin
                        state <= sac_pkg::SAC_XFER;
                    end
                end
                sac_pkg::SAC_XFER: begin
                    if (last_fall) begin
                        state <= sac_pkg::SAC_HOLD;
                    end
                end
                sac_pkg::SAC_HOLD: begin
                    state <= sac_pkg::SAC_HOLD;
                end
            endcase
        end
    end

    // Setup guard: shift clock edges seen here are dropped, filtering stray shift clock pulses
    always_ff @(posedge sys_clk) begin
        if (!rst_n || sel_fall) begin
            setup_cnt <= '0;
        end else if (state == sac_pkg::SAC_SETUP) begin
            setup_cnt <= setup_cnt + sac_pkg::TIMER_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || sel_fall) begin
            rise_cnt <= '0;
            fall_cnt <= '0;
        end else begin
            if (xfer_rise && rise_cnt != sac_pkg::CNT_W'(XFER_BITS)) begin
                rise_cnt <= rise_cnt + sac_pkg::CNT_W'(1);
            end
            if (xfer_fall && fall_cnt != sac_pkg::CNT_W'(XFER_BITS)) begin
                fall_cnt <= fall_cnt + sac_pkg::CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial input capture

    logic [XFER_BITS-1:0] in_shift;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            in_shift <= '0;
        end else if (xfer_rise) begin
            in_shift <= {in_shift[XFER_BITS-2:0], sdi_s};
        end
    end

    // Address latches on the fourth rise and feeds the multiplexer at once
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            chan_sel   <= sac_pkg::ADDR_RST;
            chan_valid <= 1'b0;
        end else if (sel_fall) begin
            chan_valid <= 1'b0;
        end else if (xfer_rise && rise_cnt == sac_pkg::CNT_W'(sac_pkg::ADDR_BITS - 1)) begin
            chan_sel   <= {in_shift[sac_pkg::ADDR_BITS-2:0], sdi_s};
            chan_valid <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmd_word <= '0;
        end else if (xfer_rise && rise_cnt == sac_pkg::CNT_W'(sac_pkg::CMD_BITS - 1)) begin
            cmd_word <= {in_shift[sac_pkg::CMD_BITS-2:0], sdi_s};
        end
    end

    // Sampling window runs from the fourth fall to the last fall
    always_ff @(posedge sys_clk) begin
        if (!rst_n || sel_fall || sel_rise) begin
            sampling <= 1'b0;
        end else if (last_fall) begin
            sampling <= 1'b0;
        end else if (xfer_fall && fall_cnt == sac_pkg::CNT_W'(sac_pkg::ADDR_BITS - 1)) begin
            sampling <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result buffer and serial output

    sac_stream_if #(.WIDTH(RESULT_W)) push_if ();
    sac_stream_if #(.WIDTH(RESULT_W)) pop_if ();

    sac_fifo #(
        .WIDTH (RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr      (push_if.snk),
        .rd      (pop_if.src)
    );

    logic [RESULT_W-1:0] out_shift;
    logic [RESULT_W-1:0] last_result;
    logic [RESULT_W-1:0] next_word;

    // An empty buffer repeats the last result rather than stalling the host
    assign pop_if.ready = sel_fall;
    assign next_word    = pop_if.valid ? pop_if.data : last_result;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            last_result <= sac_pkg::RESULT_RST;
        end else if (sel_fall) begin
            last_result <= next_word;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            out_shift <= sac_pkg::RESULT_RST;
        end else if (sel_fall) begin
            out_shift <= next_word;
        end else if (xfer_fall && !last_fall) begin
            if (lsb_first) begin
                out_shift <= {1'b0, out_shift[RESULT_W-1:1]};
            end else begin
                out_shift <= {out_shift[RESULT_W-2:0], 1'b0};
            end
        end
    end

    assign sdo = lsb_first ? out_shift[0] : out_shift[RESULT_W-1];

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= !sel_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    logic                        conv_busy;
    logic                        push_pend;
    logic [sac_pkg::TIMER_W-1:0] conv_cnt;
    logic [RESULT_W-1:0]         push_data;

    assign push_if.valid = push_pend;
    assign push_if.data  = push_data;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= last_fall;
        end
    end

    // A full buffer holds the finished word and keeps done low until room appears
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            conv_busy <= 1'b0;
            push_pend <= 1'b0;
            conv_cnt  <= '0;
            push_data <= sac_pkg::RESULT_RST;
        end else if (last_fall) begin
            conv_busy <= 1'b1;
            push_pend <= 1'b0;
            conv_cnt  <= '0;
        end else if (conv_busy) begin
            if (conv_cnt == sac_pkg::TIMER_W'(sac_pkg::CONV_CYC - 1)) begin
                conv_busy <= 1'b0;
                push_pend <= 1'b1;
                push_data <= conv_result;
            end else begin
                conv_cnt <= conv_cnt + sac_pkg::TIMER_W'(1);
            end
        end else if (push_pend && push_if.ready) begin
            push_pend <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            conv_done <= 1'b1;
        end else if (last_fall) begin
            conv_done <= 1'b0;
        end else if (push_pend && push_if.ready) begin
            conv_done <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_sdo_hiz: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sel_s && sel_d |=> !sdo_oe)
        else $error("serial output driven while select high");

    chk_sdo_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sel_fall |=> sdo_oe && out_shift == $past(next_word))
        else $error("select fall did not drive first result bit");

    chk_fall_shift: assert property (@(posedge sys_clk) disable iff (!rst_n)
        xfer_fall && !last_fall && !sel_rise && !lsb_first
        |=> out_shift == {$past(out_shift[RESULT_W-2:0]), 1'b0})
        else $error("output did not advance on shift clock fall");

    chk_rise_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sclk_rise && !sel_fall |=> $stable(out_shift))
        else $error("output changed on a rising edge");

    chk_done_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        last_fall |=> !conv_done [*8])
        else $error("done not held low after final fall");

    chk_addr_valid: assert property (@(posedge sys_clk) disable iff (!rst_n)
        xfer_rise && rise_cnt == 4'h3 && !sel_fall
        |=> chan_valid && chan_sel == {$past(in_shift[2:0]), $past(sdi_s)})
        else $error("channel not selected after fourth rise");

    chk_cmd_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
        xfer_rise && rise_cnt == 4'h7 && !sel_fall
        |=> cmd_word == {$past(in_shift[6:0]), $past(sdi_s)})
        else $error("input data register not loaded on eighth rise");

    chk_sample_win: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sampling |-> state == sac_pkg::SAC_XFER && fall_cnt >= 4'h4)
        else $error("sampling outside its window");

    chk_setup_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == sac_pkg::SAC_SETUP && !sel_fall |=> rise_cnt == 4'h0 && fall_cnt == 4'h0)
        else $error("shift clock accepted during setup guard");

    chk_sel_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sel_rise |=> state == sac_pkg::SAC_IDLE ##1 $stable(rise_cnt))
        else $error("serial input still accepted after select rose");

    chk_done_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(conv_done) |-> $past(push_pend) && $past(push_if.ready))
        else $error("done rose without a finished result");

    chk_conv_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        last_fall |=> conv_start && conv_busy ##1 conv_busy [*8])
        else $error("conversion not handed to sequencer");

endmodule : sac_serial_ctrl

`default_nettype wire

// ===== core/sac_pkg.sv
package sac_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS      = 1425;
    localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_NS       = 10000;
    localparam int CONV_CYC      = CONV_NS / CLK_PERIOD_NS;
    localparam int TIMER_W       = 11;

    // Word layout
    localparam int RESULT_W  = 12;
    localparam int ADDR_BITS = 4;
    localparam int CMD_BITS  = 8;
    localparam int XFER_BITS = 12;
    localparam int CNT_W     = 4;
    localparam int FIFO_DEPTH = 4;

    // Reset values
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
    localparam logic [ADDR_BITS-1:0] ADDR_RST  = 4'h0;

    typedef enum logic [1:0] {
        SAC_IDLE  = 2'h0,
        SAC_SETUP = 2'h1,
        SAC_XFER  = 2'h2,
        SAC_HOLD  = 2'h3
    } sac_state_t;

endpackage : sac_pkg

// ===== core/sac_stream_if.sv
`timescale 1ns/1ns
`default_nettype none

interface sac_stream_if #(parameter int WIDTH = 12);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : sac_stream_if

`default_nettype wire

// ===== core/sac_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module sac_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic   sys_clk,
    input  wire logic   rst_n,
    // Fill and drain sides
    sac_stream_if.snk   wr,
    sac_stream_if.src   rd
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
        $error("sac_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW:0]      cnt;
    logic             do_wr;
    logic             do_rd;

    assign wr.ready = (cnt != (AW+1)'(DEPTH));
    assign rd.valid = (cnt != '0);
    assign rd.data  = mem[rp];
    assign do_wr    = wr.valid && wr.ready;
    assign do_rd    = rd.valid && rd.ready;

    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wp] <= wr.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (do_wr) begin
                wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1);
            end
            if (do_rd) begin
                rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (do_wr && !do_rd) begin
            cnt <= cnt + (AW+1)'(1);
        end else if (do_rd && !do_wr) begin
            cnt <= cnt - (AW+1)'(1);
        end
    end

endmodule : sac_fifo

`default_nettype wire

// ===== sim/sac_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module sac_host_model (
    // Link pins
    output logic      sel_n,
    output logic      shift_clk,
    output logic      sdi,
    input  wire logic sdo_pin
);

    // Shift clock stands still low outside frames
    initial begin
        sel_n     = 1'b1;
        shift_clk = 1'b0;
        sdi       = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One frame: address and command MSB first, result sampled on each rise
    task automatic transfer(input logic [7:0] cmd, input int pulses, input bit early,
                            output logic [11:0] rx);
        logic [11:0] din;
        din = {cmd, 4'h0};
        rx = 12'h000;
        // Step off the system clock edge so the pin flops never race the model
        #1 sel_n = 1'b0;
        // Stray pulses inside the guard must be ignored by the device
        if (early) begin
            repeat (2) begin
                #100 shift_clk = 1'b1;
                #100 shift_clk = 1'b0;
            end
        end
        #1600;
        for (int k = 0; k < pulses; k++) begin
            sdi = din[11-k];
            #62 shift_clk = 1'b1;
            rx[11-k] = sdo_pin;
            #63 shift_clk = 1'b0;
        end
        #100 sel_n = 1'b1;
        // Released line shows the inverse so no stale bit reads as valid
        sdi = ~sdi;
    endtask : transfer

endmodule : sac_host_model

`default_nettype wire

// ===== sim/sac_serial_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module sac_serial_ctrl_tb_top;

    logic        sys_clk     = 1'b0;
    logic        rst_n       = 1'b0;
    logic        lsb_first   = 1'b0;
    logic [11:0] conv_result = 12'h000;
    wire logic   sel_n;
    wire logic   shift_clk;
    wire logic   sdi;
    wire logic   sdo_pin;
    logic        sdo;
    logic        sdo_oe;
    logic        conv_done;
    logic [3:0]  chan_sel;
    logic        chan_valid;
    logic [7:0]  cmd_word;
    logic        sampling;
    logic        conv_start;
    int          fail_count  = 0;
    int          check_count = 0;
    int          cyc         = 0;
    int          samp_cnt    = 0;
    int          start_cnt   = 0;
    int          wait_cnt    = 0;
    int          last_wait   = 0;
    logic        done_q      = 1'b1;

    assign sdo_pin = sdo_oe ? sdo : 1'bz;

    sac_serial_ctrl sac_serial_ctrl_i (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .sel_n       (sel_n),
        .shift_clk   (shift_clk),
        .sdi         (sdi),
        .sdo         (sdo),
        .sdo_oe      (sdo_oe),
        .conv_done   (conv_done),
        .lsb_first   (lsb_first),
        .chan_sel    (chan_sel),
        .chan_valid  (chan_valid),
        .cmd_word    (cmd_word),
        .sampling    (sampling),
        .conv_start  (conv_start),
        .conv_result (conv_result)
    );

    sac_host_model sac_host_model_i (
        .sel_n     (sel_n),
        .shift_clk (shift_clk),
        .sdi       (sdi),
        .sdo_pin   (sdo_pin)
    );

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reporting
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    function automatic logic [11:0] flip(input logic [11:0] v);
        for (int b = 0; b < 12; b++)
            flip[b] = v[11-b];
    endfunction : flip

    ////////////////////////////////////////////////////////////////////////////
    // Monitor: sampling width, start pulses, conversion time, run ceiling
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (sampling === 1'b1)
            samp_cnt <= samp_cnt + 1;
        if (conv_start === 1'b1) begin
            start_cnt <= start_cnt + 1;
            wait_cnt  <= 0;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
        if (conv_done === 1'b1 && done_q === 1'b0)
            last_wait <= wait_cnt;
        done_q <= conv_done;
        if (cyc == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic wait_done;
        for (int n = 0; n < 1200 && conv_done !== 1'b1; n++)
            @(posedge sys_clk);
        // Let this edge's updates, the monitor's too, settle before anyone looks
        #1;
    endtask : wait_done

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset;
        check_val({sdo_oe, conv_done, chan_valid, sampling, conv_start, 7'h00}, 12'h400);
        check_val({chan_sel, cmd_word}, 12'h000);
        $display("test_reset done");
    endtask : test_reset

    // Each frame reads the result of the conversion started by the frame before
    task automatic test_transfers(output logic [11:0] last_res);
        logic [11:0] rx;
        logic [11:0] exp;
        logic [11:0] res;
        logic [3:0]  a;
        int          s0;
        int          p0;
        exp = 12'h000;
        for (int i = 0; i < 16; i++) begin
            a = i[3:0];
            res = {~a, a, a ^ 4'hA};
            @(posedge sys_clk);
            conv_result <= res;
            lsb_first   <= a[0];
            @(posedge sys_clk);
            s0 = start_cnt;
            p0 = samp_cnt;
            sac_host_model_i.transfer({a, ~a}, 12, i == 5, rx);
            check_val(rx, a[0] ? flip(exp) : exp);
            check_val({chan_sel, cmd_word}, {a, a, ~a});
            check_val({11'h000, chan_valid}, 12'h001);
            check_val({11'h000, conv_done}, 12'h000);
            check_val(12'(start_cnt - s0), 12'h001);
            check_val({11'h000, (samp_cnt - p0) inside {[99:101]}}, 12'h001);
            repeat (10) @(posedge sys_clk);
            check_val({11'h000, sdo_oe}, 12'h000);
            wait_done();
            check_val({11'h000, conv_done}, 12'h001);
            check_val({11'h000, last_wait inside {[998:1000]}}, 12'h001);
            exp = res;
        end
        last_res = exp;
        $display("test_transfers done");
    endtask : test_transfers

    // A frame cut short after three bits leaves no conversion behind
    task automatic test_abort(input logic [11:0] last_res);
        logic [11:0] rx;
        int          s0;
        @(posedge sys_clk);
        lsb_first <= 1'b0;
        @(posedge sys_clk);
        s0 = start_cnt;
        sac_host_model_i.transfer(8'h9F, 3, 0, rx);
        repeat (20) @(posedge sys_clk);
        check_val({11'h000, chan_valid}, 12'h000);
        check_val(12'(start_cnt - s0), 12'h000);
        check_val({11'h000, conv_done}, 12'h001);
        sac_host_model_i.transfer(8'h3C, 12, 0, rx);
        check_val({chan_sel, cmd_word}, 12'h33C);
        check_val(rx, last_res);
        wait_done();
        check_val({11'h000, conv_done}, 12'h001);
        $display("test_abort done");
    endtask : test_abort

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [11:0] last_res;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        test_reset();
        test_transfers(last_res);
        test_abort(last_res);
        tally_and_finish();
    end

endmodule : sac_serial_ctrl_tb_top

`default_nettype wire
